// ==== rtl/corr_filter.sv ====
// per-line correction tracker deciding which corrections get posted
`timescale 1ns/1ps
`default_nettype none
module corr_filter #(
  parameter int ENTRIES = 4,
  parameter int LINE_W = 16,
  parameter logic [7:0] THRESH = 8'h02
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  corr_filter_if.tracker fi
);
  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  logic [LINE_W-1:0] tag [ENTRIES];
  logic [7:0] cnt [ENTRIES];
  logic [ENTRIES-1:0] used;
  logic [IDX_W-1:0] victim;
  logic hit;
  logic [IDX_W-1:0] hit_idx;

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (!hit && used[i] && tag[i] == fi.line) begin
        hit = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

  // uncorrected always posts; corrections only up to the threshold
  assign fi.post = !fi.corrected || !hit || (cnt[hit_idx] < THRESH);
  // last posting before suppression marks the filter bit, for compound error kinds only
  assign fi.last = fi.corrected &&
                   (hit ? (cnt[hit_idx] + 8'h01 == THRESH) : (THRESH == 8'h01));

  // once saturated a line stays silent until flushed or evicted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      used <= '0;
      victim <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        tag[i] <= '0;
        cnt[i] <= 8'h00;
      end
    end else if (fi.flush) begin
      used <= '0;
    end else if (fi.req && fi.corrected) begin
      if (hit) begin
        if (cnt[hit_idx] < THRESH) begin
          cnt[hit_idx] <= cnt[hit_idx] + 8'h01;
        end
      end else begin
        used[victim] <= 1'b1;
        tag[victim] <= fi.line;
        cnt[victim] <= 8'h01;
        victim <= (victim == IDX_W'(ENTRIES - 1)) ? '0 : victim + IDX_W'(1);
      end
    end
  end
endmodule // corr_filter
`default_nettype wire

// ==== rtl/corr_filter_if.sv ====
// signals between the logger and its correction filter
`timescale 1ns/1ps
`default_nettype none
interface corr_filter_if #(parameter int LINE_W = 16);
  logic req;
  logic corrected;
  logic [LINE_W-1:0] line;
  logic flush;
  logic post;
  logic last;
  modport tracker(input req, input corrected, input line, input flush, output post, output last);
  modport logger(output req, output corrected, output line, output flush, input post, input last);
endinterface
`default_nettype wire

// ==== rtl/mc_bank_logger.sv ====
// machine-check error bank logger with register port
`timescale 1ns/1ps
`default_nettype none
module mc_bank_logger #(
  parameter int BANKS = 4,
  parameter int BANK_W = 2,
  parameter int LINE_W = 16,
  parameter int FILTER_ENTRIES = 4,
  parameter logic [7:0] FILTER_THRESH = 8'h02
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic err_valid_i,
  input wire logic [BANK_W-1:0] err_bank_i,
  input wire logic [3:0] err_kind_i,
  input wire logic [11:0] err_detail_i,
  input wire logic [15:0] err_model_code_i,
  input wire logic err_uncorrected_i,
  input wire logic [LINE_W-1:0] err_line_i,
  input wire logic bus_init_n_i,
  input wire logic bus_init_strap_i,
  output logic machine_check_exception_o
);
  // reset release through two flops
  // assertion stays asynchronous; only the release is timed to the clock
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // bank register storage
  logic [31:0] bank_ctl [BANKS];
  logic [31:0] stat_lo [BANKS];
  logic [BANKS-1:0] stat_valid;
  logic [BANKS-1:0] stat_uc;
  logic [BANKS-1:0] stat_filt;
  logic [31:0] ctrl;
  logic strap_seen;
  logic strap_taken;
  logic [15:0] suppressed_cnt;
  logic [15:0] lost_cnt;

  // address decode
  function automatic logic in_banks(input logic [7:0] a);
    return (a >= mc_log_pkg::OFS_BANK_BASE) &&
           (a < mc_log_pkg::OFS_BANK_BASE + 8'(BANKS << mc_log_pkg::BANK_STRIDE_LSB));
  endfunction

  function automatic logic [BANK_W-1:0] bank_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - mc_log_pkg::OFS_BANK_BASE;
    return BANK_W'(off >> mc_log_pkg::BANK_STRIDE_LSB);
  endfunction

  logic wr_bank;
  logic [BANK_W-1:0] wr_idx;
  logic [3:0] wr_fld;
  assign wr_bank = reg_we_i && in_banks(reg_addr_i);
  assign wr_idx = bank_of(reg_addr_i);
  assign wr_fld = reg_addr_i[3:0];

  // strap pin passes three flops like the bus-init pin
  logic strap_s1;
  logic strap_s2;
  logic strap_s3;
  logic [1:0] strap_age;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_s3 <= 1'b0;
      strap_age <= 2'h0;
    end else begin
      strap_s1 <= bus_init_strap_i;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_age != 2'h3) begin
        strap_age <= strap_age + 2'h1;
      end
    end
  end

  // strap is caught once after reset release
  // waiting for a full chain keeps the flops' reset value from posing as the strap
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_seen <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken && strap_age == 2'h3 && strap_s2 == strap_s3) begin
      strap_seen <= strap_s3;
      strap_taken <= 1'b1;
    end
  end

  // bus-init pin: three flops, a change counts when second and third agree
  logic bi_s1;
  logic bi_s2;
  logic bi_s3;
  logic bi_lvl;
  logic bi_rise;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bi_s1 <= 1'b0;
      bi_s2 <= 1'b0;
      bi_s3 <= 1'b0;
      bi_lvl <= 1'b0;
    end else begin
      bi_s1 <= !bus_init_n_i;
      bi_s2 <= bi_s1;
      bi_s3 <= bi_s2;
      if (bi_s2 == bi_s3) begin
        bi_lvl <= bi_s3;
      end
    end
  end
  assign bi_rise = bi_s2 && bi_s3 && !bi_lvl;

  // control register, software steered
  logic machine_check_enable_bit;
  assign machine_check_enable_bit = ctrl[mc_log_pkg::CTRL_MCE_BIT];
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= mc_log_pkg::CTRL_RESET;
    end else if (reg_we_i && reg_addr_i == mc_log_pkg::OFS_CTRL) begin
      // flush is a self-clearing command, never stored
      ctrl <= reg_wdata_i & ~(32'h1 << mc_log_pkg::CTRL_FLUSH_BIT);
    end
  end

  // correction filter
  logic bi_ext;
  corr_filter_if #(.LINE_W(LINE_W)) fif ();
  assign fif.req = err_valid_i && !bi_ext;
  assign fif.corrected = !err_uncorrected_i;
  assign fif.line = err_line_i;
  assign fif.flush = reg_we_i && reg_addr_i == mc_log_pkg::OFS_CTRL &&
                     reg_wdata_i[mc_log_pkg::CTRL_FLUSH_BIT];

  corr_filter #(
    .ENTRIES(FILTER_ENTRIES),
    .LINE_W(LINE_W),
    .THRESH(FILTER_THRESH)
  ) u_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .fi(fif.tracker)
  );

  // event selection: bus-init external error takes priority
  logic post;
  logic [BANK_W-1:0] log_bank;
  logic [15:0] log_code;
  logic [15:0] log_model;
  logic log_uc;
  logic log_filt;
  logic bank_open;
  logic do_log;
  mc_log_pkg::err_kind_t kind;

  assign bi_ext = bi_rise && strap_seen;
  assign kind = mc_log_pkg::err_kind_t'(err_kind_i);

  always_comb begin
    post = 1'b0;
    log_bank = '0;
    log_code = mc_log_pkg::CODE_NONE;
    log_model = 16'h0000;
    log_uc = 1'b0;
    log_filt = 1'b0;
    if (bi_ext) begin
      post = 1'b1;
      log_code = mc_log_pkg::encode_code(mc_log_pkg::K_EXTERNAL, 12'h000, 1'b0);
      log_uc = 1'b1;
    end else if (err_valid_i && fif.post) begin
      post = 1'b1;
      log_bank = err_bank_i;
      log_filt = fif.last && mc_log_pkg::is_compound(kind);
      log_code = mc_log_pkg::encode_code(kind, err_detail_i, log_filt);
      log_model = err_model_code_i;
      log_uc = err_uncorrected_i;
    end
  end

  // an enabled bank with no entry pending takes the event
  // a clearing write in the same cycle frees the bank, so the new entry wins
  // any nonzero control word enables the bank; its bits are not decoded further
  logic clear_now;
  assign clear_now = wr_bank && wr_idx == log_bank && wr_fld == mc_log_pkg::BANK_STHI &&
                     !reg_wdata_i[mc_log_pkg::STHI_VALID_BIT];
  assign bank_open = (bank_ctl[log_bank] != 32'h0) &&
                     (!stat_valid[log_bank] || clear_now);
  assign do_log = post && bank_open;

  // bank control registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_ctl[i] <= mc_log_pkg::BANK_CTL_RESET;
      end
    end else if (wr_bank && wr_fld == mc_log_pkg::BANK_CTL) begin
      bank_ctl[wr_idx] <= reg_wdata_i;
    end
  end

  // bank status: hardware log wins over a same-cycle software write
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_valid <= '0;
      stat_uc <= '0;
      stat_filt <= '0;
      for (int i = 0; i < BANKS; i++) begin
        stat_lo[i] <= mc_log_pkg::STATUS_RESET;
      end
    end else begin
      for (int i = 0; i < BANKS; i++) begin
        if (do_log && log_bank == BANK_W'(i)) begin
          stat_lo[i] <= {log_model, log_code};
          stat_valid[i] <= 1'b1;
          stat_uc[i] <= log_uc;
          stat_filt[i] <= log_filt;
        end else if (wr_bank && wr_idx == BANK_W'(i)) begin
          // entry stays frozen until software rewrites it
          if (wr_fld == mc_log_pkg::BANK_STLO) begin
            stat_lo[i] <= reg_wdata_i;
          end else if (wr_fld == mc_log_pkg::BANK_STHI) begin
            stat_valid[i] <= reg_wdata_i[mc_log_pkg::STHI_VALID_BIT];
            stat_uc[i] <= reg_wdata_i[mc_log_pkg::STHI_UC_BIT];
            stat_filt[i] <= reg_wdata_i[mc_log_pkg::STHI_FILT_BIT];
          end
        end
      end
    end
  end

  // diagnostic counters: filtered corrections and events with no free bank
  // counters saturate at 0xffff; the info word shows only the low byte of the lost count, which wraps to zero every 256 events
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      suppressed_cnt <= 16'h0000;
      lost_cnt <= 16'h0000;
    end else begin
      if (fif.req && !fif.post && suppressed_cnt != 16'hffff) begin
        suppressed_cnt <= suppressed_cnt + 16'h0001;
      end
      if (post && !bank_open && lost_cnt != 16'hffff) begin
        lost_cnt <= lost_cnt + 16'h0001;
      end
    end
  end

  // exception pulse: only uncorrected events, only while enabled
  // corrected events are logged quietly and never interrupt
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      machine_check_exception_o <= 1'b0;
    end else begin
      machine_check_exception_o <= machine_check_enable_bit && (bi_ext || (err_valid_i && err_uncorrected_i));
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  logic [31:0] rd_val;
  logic [BANK_W-1:0] rd_idx;
  assign rd_idx = bank_of(reg_addr_i);
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr_i == mc_log_pkg::OFS_GCAP) begin
      rd_val = 32'(BANKS);
      rd_val[mc_log_pkg::GCAP_FILTER_BIT] = 1'b1;
    end else if (reg_addr_i == mc_log_pkg::OFS_CTRL) begin
      rd_val = ctrl;
    end else if (reg_addr_i == mc_log_pkg::OFS_INFO) begin
      rd_val = {strap_seen, 7'h00, lost_cnt[7:0], suppressed_cnt};
    end else if (in_banks(reg_addr_i)) begin
      if (reg_addr_i[3:0] == mc_log_pkg::BANK_CTL) begin
        rd_val = bank_ctl[rd_idx];
      end else if (reg_addr_i[3:0] == mc_log_pkg::BANK_STLO) begin
        rd_val = stat_lo[rd_idx];
      end else if (reg_addr_i[3:0] == mc_log_pkg::BANK_STHI) begin
        rd_val[mc_log_pkg::STHI_VALID_BIT] = stat_valid[rd_idx];
        rd_val[mc_log_pkg::STHI_UC_BIT] = stat_uc[rd_idx];
        rd_val[mc_log_pkg::STHI_FILT_BIT] = stat_filt[rd_idx];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_val : 32'h0000_0000;
    end
  end
endmodule // mc_bank_logger
`default_nettype wire

// ==== rtl/mc_log_pkg.sv ====
// constants, encodings and helpers for the machine-check bank logger
// Overview of operation
// - exceptions only with enable bit 6 set
// - log 16-bit code and set valid flag
// - optionally log 16-bit model-specific code
// - code bits 15:0 alone name the error
// - codes: none 0, unclassified 1, ROM parity 2
// - codes: bus-init 3, mismatch 4, parity 5
// - timer 0x0400, internal unclassified 000001 nonzero
// - bus-init traps only if strapped and enabled
// - TLB, memory controller, cache compound forms
// - generic cache form 000F 0000 0000 11LL
// - bus form 000F 1PPT REQUEST_TYPE_FIELD IILL
// - bit 12 flags filtering active for entry
// - post first few corrections per line only
// - uncorrected errors always posted; one arriving in the same cycle as a bus-init event is dropped
// - capability bit 11 advertises filtering
// - transaction type: instr 00, data 01, generic 10
// - level: 0,1,2 then generic 11
// - request codes 0000 through snoop 1000
`default_nettype none
package mc_log_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 16;
  localparam int DETAIL_W = 12;
  localparam int KIND_W = 4;

  // register byte offsets
  localparam logic [7:0] OFS_GCAP = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_INFO = 8'h08;
  localparam logic [7:0] OFS_BANK_BASE = 8'h40;
  localparam int BANK_STRIDE_LSB = 4;
  localparam logic [3:0] BANK_CTL = 4'h0;
  localparam logic [3:0] BANK_STLO = 4'h4;
  localparam logic [3:0] BANK_STHI = 4'h8;

  // field positions
  localparam int GCAP_FILTER_BIT = 11;
  localparam int CTRL_FLUSH_BIT = 0;
  localparam int CTRL_MCE_BIT = 6;
  localparam int STHI_VALID_BIT = 31;
  localparam int STHI_UC_BIT = 30;
  localparam int STHI_FILT_BIT = 29;
  localparam int INFO_STRAP_BIT = 31;
  localparam int CODE_FILTER_BIT = 12;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BANK_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // simple codes
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_UNCLASS = 16'h0001;
  localparam logic [15:0] CODE_UROM_PARITY = 16'h0002;
  localparam logic [15:0] CODE_EXTERNAL = 16'h0003;
  localparam logic [15:0] CODE_MISMATCH = 16'h0004;
  localparam logic [15:0] CODE_INT_PARITY = 16'h0005;
  localparam logic [15:0] CODE_TIMER = 16'h0400;
  localparam logic [5:0] CODE_INT_UNCLASS_TOP = 6'h01;

  // sub-field encodings
  localparam logic [1:0] TT_INSTR = 2'h0;
  localparam logic [1:0] TT_DATA = 2'h1;
  localparam logic [1:0] TT_GENERIC = 2'h2;
  localparam logic [1:0] LL_0 = 2'h0;
  localparam logic [1:0] LL_1 = 2'h1;
  localparam logic [1:0] LL_2 = 2'h2;
  localparam logic [1:0] LL_GENERIC = 2'h3;
  localparam logic [3:0] REQ_ERR = 4'h0;
  localparam logic [3:0] REQ_RD = 4'h1;
  localparam logic [3:0] REQ_WR = 4'h2;
  localparam logic [3:0] REQ_DRD = 4'h3;
  localparam logic [3:0] REQ_DWR = 4'h4;
  localparam logic [3:0] REQ_FETCH = 4'h5;
  localparam logic [3:0] REQ_PREFETCH = 4'h6;
  localparam logic [3:0] REQ_EVICT = 4'h7;
  localparam logic [3:0] REQ_SNOOP = 4'h8;

  typedef enum logic [3:0] {
    K_UNCLASS, K_UROM_PARITY, K_EXTERNAL, K_MISMATCH, K_INT_PARITY, K_TIMER,
    K_INT_UNCLASS, K_GEN_CACHE, K_TLB, K_MEMCTL, K_CACHE, K_BUS
  } err_kind_t;

  function automatic logic is_compound(input err_kind_t k);
    return k inside {K_GEN_CACHE, K_TLB, K_MEMCTL, K_CACHE, K_BUS};
  endfunction

  // builds bits 15:0 from cause, sub-fields and filter flag
  function automatic logic [15:0] encode_code(input err_kind_t k,
                                              input logic [11:0] d,
                                              input logic f);
    logic [15:0] c;
    c = CODE_UNCLASS;
    unique case (k)
      K_UNCLASS: c = CODE_UNCLASS;
      K_UROM_PARITY: c = CODE_UROM_PARITY;
      K_EXTERNAL: c = CODE_EXTERNAL;
      K_MISMATCH: c = CODE_MISMATCH;
      K_INT_PARITY: c = CODE_INT_PARITY;
      K_TIMER: c = CODE_TIMER;
      // low ten bits may never be all zero
      K_INT_UNCLASS: c = {CODE_INT_UNCLASS_TOP, (d[9:0] == 10'h000) ? 10'h001 : d[9:0]};
      K_GEN_CACHE: c = {3'h0, f, 8'h00, 2'h3, d[1:0]};
      K_TLB: c = {3'h0, f, 8'h01, d[3:0]};
      K_MEMCTL: c = {3'h0, f, 5'h01, d[6:0]};
      K_CACHE: c = {3'h0, f, 4'h1, d[7:0]};
      K_BUS: c = {3'h0, f, 1'b1, d[10:0]};
      // codes 12 to 15 can arrive on the pin; log them as unclassified
      default: c = CODE_UNCLASS;
    endcase
    return c;
  endfunction
endpackage
`default_nettype wire

// ==== testbench/mc_bank_logger_monitor.sv ====
// bound checker on the ports of the machine-check bank logger
`timescale 1ns/1ps
`default_nettype none
module mc_bank_logger_monitor #(
  parameter int BANKS = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic err_valid_i,
  input wire logic err_uncorrected_i,
  input wire logic bus_init_n_i,
  input wire logic bus_init_strap_i,
  input wire logic machine_check_exception_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic mce_q;
  logic [31:0] ctl0_q;
  // shadows follow software writes only; hardware never changes these registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mce_q <= 1'b0;
      ctl0_q <= 32'h0;
    end else if (reg_we_i) begin
      if (reg_addr_i == mc_log_pkg::OFS_CTRL) mce_q <= reg_wdata_i[6];
      if (reg_addr_i == mc_log_pkg::OFS_BANK_BASE) ctl0_q <= reg_wdata_i;
    end
  end
  rdata_idle_a:
    assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  gcap_read_a:
    assert property (reg_re_i && reg_addr_i == mc_log_pkg::OFS_GCAP |=>
      reg_rdata_o[7:0] == 8'(BANKS) && reg_rdata_o[11])
    else $error("capability word wrong");
  ctrl_read_a:
    assert property (reg_re_i && reg_addr_i == mc_log_pkg::OFS_CTRL |=>
      reg_rdata_o[6] == $past(mce_q) && !reg_rdata_o[0])
    else $error("control word readback wrong");
  unmapped_read_a:
    assert property (reg_re_i && reg_addr_i >= 8'(64 + BANKS * 16) |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  exc_mce_a:
    assert property (machine_check_exception_o |-> $past(mce_q))
    else $error("exception while enable bit clear");
  exc_cause_a:
    assert property (machine_check_exception_o |-> $past(err_valid_i && err_uncorrected_i)
      || !$past(bus_init_n_i, 3) || !$past(bus_init_n_i, 4) || !$past(bus_init_n_i, 5))
    else $error("exception without a cause");
  bus_init_a:
    assert property ($fell(bus_init_n_i) && bus_init_strap_i && mce_q |->
      ##[3:5] machine_check_exception_o)
    else $error("bus init did not trap");
  info_strap_a:
    assert property (reg_re_i && reg_addr_i == mc_log_pkg::OFS_INFO |=>
      reg_rdata_o[31] == $past(bus_init_strap_i))
    else $error("strap bit readback wrong");
  ctl_readback_a:
    assert property (reg_re_i && reg_addr_i == mc_log_pkg::OFS_BANK_BASE |=>
      reg_rdata_o == $past(ctl0_q))
    else $error("bank control readback wrong");
endmodule // mc_bank_logger_monitor
bind mc_bank_logger mc_bank_logger_monitor #(.BANKS(BANKS)) mon_u (.clk_i(clk_i),
  .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .err_valid_i(err_valid_i),
  .err_uncorrected_i(err_uncorrected_i), .bus_init_n_i(bus_init_n_i),
  .bus_init_strap_i(bus_init_strap_i), .machine_check_exception_o(machine_check_exception_o));
`default_nettype wire

// ==== testbench/mc_bank_logger_test.sv ====
// self-checking bench for the machine-check bank logger
`timescale 1ns/1ps
`default_nettype none
module mc_bank_logger_test;
  localparam logic [15:0] MC = 16'hc35a;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic err_valid_i = 1'b0;
  logic [1:0] err_bank_i = 2'h0;
  logic [3:0] err_kind_i = 4'h0;
  logic [11:0] err_detail_i = 12'h000;
  logic [15:0] err_model_code_i = MC;
  logic err_uncorrected_i = 1'b0;
  logic [15:0] err_line_i = 16'h0000;
  logic bus_init_n_i = 1'b1;
  logic bus_init_strap_i = 1'b1;
  logic machine_check_exception_o;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [15:0] ln = 16'h0100;
  mc_bank_logger dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .err_valid_i(err_valid_i), .err_bank_i(err_bank_i),
    .err_kind_i(err_kind_i), .err_detail_i(err_detail_i), .err_model_code_i(err_model_code_i),
    .err_uncorrected_i(err_uncorrected_i), .err_line_i(err_line_i),
    .bus_init_n_i(bus_init_n_i), .bus_init_strap_i(bus_init_strap_i),
    .machine_check_exception_o(machine_check_exception_o));
  always #5 clk_i = ~clk_i;
  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ba(input int b, input logic [3:0] o);
    return mc_log_pkg::OFS_BANK_BASE + 8'(b * 16) + {4'h0, o};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 rv = reg_rdata_o;
    chk(rv & m, e);
  endtask
  task automatic clr(input int b);
    wr(ba(b, mc_log_pkg::BANK_STHI), 32'h0);
    wr(ba(b, mc_log_pkg::BANK_STLO), 32'h0);
  endtask
  task automatic fire(input int b, input logic [3:0] k, input logic [11:0] d,
                      input logic uc, input logic x);
    @(posedge clk_i);
    err_valid_i <= 1'b1;
    err_bank_i <= 2'(b);
    err_kind_i <= k;
    err_detail_i <= d;
    err_uncorrected_i <= uc;
    err_line_i <= ln;
    @(posedge clk_i);
    err_valid_i <= 1'b0;
    #1 chk({31'h0, machine_check_exception_o}, {31'h0, x});
  endtask
  // logs one event, checks both status words, then frees the bank
  task automatic post(input int b, input logic [3:0] k, input logic [11:0] d, input logic uc,
                      input logic x, input logic [15:0] c, input logic [31:0] hi);
    fire(b, k, d, uc, x);
    rc(ba(b, mc_log_pkg::BANK_STLO), {MC, c}, 32'hffff_ffff);
    rc(ba(b, mc_log_pkg::BANK_STHI), hi, 32'he000_0000);
    clr(b);
  endtask
  task automatic t_reset();
    wr(mc_log_pkg::OFS_GCAP, 32'h0);
    rc(mc_log_pkg::OFS_GCAP, 32'h0000_0804, 32'h0000_08ff);
    rc(mc_log_pkg::OFS_CTRL, 32'h0, 32'hffff_ffff);
    rc(mc_log_pkg::OFS_INFO, 32'h8000_0000, 32'hffff_ffff);
    rc(8'hfc, 32'h0, 32'hffff_ffff);
    for (int b = 0; b < 4; b++) begin
      rc(ba(b, mc_log_pkg::BANK_CTL), 32'h0, 32'hffff_ffff);
      rc(ba(b, mc_log_pkg::BANK_STHI), 32'h0, 32'hffff_ffff);
      wr(ba(b, mc_log_pkg::BANK_CTL), 32'hffff_ffff);
      rc(ba(b, mc_log_pkg::BANK_CTL), 32'hffff_ffff, 32'hffff_ffff);
      clr(b);
    end
    wr(mc_log_pkg::OFS_CTRL, 32'h40);
    $display("test reset and init done");
  endtask
  task automatic t_codes();
    logic [11:0] dt [12] = '{0, 0, 0, 0, 0, 0, 0, 12'h002, 12'h006, 12'h04f, 12'h08b, 12'h5a3};
    logic [15:0] cd [12] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0400,
      16'h0401, 16'h000e, 16'h0016, 16'h00cf, 16'h018b, 16'h0da3};
    // a fresh line per event keeps the filter from marking any posting
    for (int i = 0; i < 12; i++) begin
      ln++;
      post(1, 4'(i), dt[i], 1'b1, 1'b1, cd[i], 32'hc000_0000);
    end
    for (int i = 0; i < 12; i++) begin
      ln++;
      post(1, 4'h8, 12'(i), 1'b1, 1'b1, 16'h0010 | 16'(i), 32'hc000_0000);
    end
    for (int r = 0; r < 9; r++) begin
      ln++;
      post(2, 4'ha, {4'h0, 4'(r), 4'h6}, 1'b1, 1'b1, {8'h01, 4'(r), 4'h6}, 32'hc000_0000);
    end
    $display("test codes done");
  endtask
  task automatic t_drop();
    ln++;
    fire(1, 4'h0, 12'h0, 1'b1, 1'b1);
    fire(1, 4'h4, 12'h0, 1'b0, 1'b0);
    rc(ba(1, mc_log_pkg::BANK_STLO), {MC, 16'h0001}, 32'hffff_ffff);
    wr(ba(2, mc_log_pkg::BANK_CTL), 32'h0);
    fire(2, 4'h1, 12'h0, 1'b0, 1'b0);
    rc(ba(2, mc_log_pkg::BANK_STHI), 32'h0, 32'hffff_ffff);
    rc(mc_log_pkg::OFS_INFO, 32'h0002_0000, 32'h00ff_ffff);
    wr(ba(2, mc_log_pkg::BANK_CTL), 32'hffff_ffff);
    clr(1);
    $display("test drop done");
  endtask
  task automatic t_filter();
    ln = 16'h0abc;
    post(2, 4'ha, 12'h011, 1'b0, 1'b0, 16'h0111, 32'h8000_0000);
    post(2, 4'ha, 12'h011, 1'b0, 1'b0, 16'h1111, 32'ha000_0000);
    fire(2, 4'ha, 12'h011, 1'b0, 1'b0);
    rc(ba(2, mc_log_pkg::BANK_STHI), 32'h0, 32'hffff_ffff);
    rc(mc_log_pkg::OFS_INFO, 32'h0002_0001, 32'h00ff_ffff);
    fire(2, 4'ha, 12'h011, 1'b1, 1'b1);
    rc(ba(2, mc_log_pkg::BANK_STHI), 32'hc000_0000, 32'hc000_0000);
    clr(2);
    wr(mc_log_pkg::OFS_CTRL, 32'h41);
    post(2, 4'ha, 12'h011, 1'b0, 1'b0, 16'h0111, 32'h8000_0000);
    $display("test filter done");
  endtask
  task automatic t_bus_init();
    logic seen;
    seen = 1'b0;
    wr(mc_log_pkg::OFS_CTRL, 32'h0);
    ln++;
    post(3, 4'h2, 12'h0, 1'b1, 1'b0, 16'h0003, 32'hc000_0000);
    wr(mc_log_pkg::OFS_CTRL, 32'h40);
    @(posedge clk_i);
    bus_init_n_i <= 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge clk_i);
      #1 seen = (machine_check_exception_o === 1'b1);
    end
    chk({31'h0, seen}, 32'h1);
    @(posedge clk_i);
    bus_init_n_i <= 1'b1;
    rc(ba(0, mc_log_pkg::BANK_STLO), 32'h0003, 32'h0000_ffff);
    rc(ba(0, mc_log_pkg::BANK_STHI), 32'hc000_0000, 32'hc000_0000);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    // the strap is only taken after a reset, so it changes under one
    bus_init_strap_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rc(ba(0, mc_log_pkg::BANK_STHI), 32'h0, 32'hffff_ffff);
    rc(mc_log_pkg::OFS_CTRL, 32'h0, 32'hffff_ffff);
    rc(mc_log_pkg::OFS_INFO, 32'h0, 32'hffff_ffff);
    wr(ba(0, mc_log_pkg::BANK_CTL), 32'hffff_ffff);
    wr(mc_log_pkg::OFS_CTRL, 32'h40);
    @(posedge clk_i);
    bus_init_n_i <= 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_i);
      #1 seen = seen | (machine_check_exception_o === 1'b1);
    end
    chk({31'h0, seen}, 32'h0);
    @(posedge clk_i);
    bus_init_n_i <= 1'b1;
    rc(ba(0, mc_log_pkg::BANK_STHI), 32'h0, 32'hffff_ffff);
    $display("test bus init and soft reset done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_codes();
    t_drop();
    t_filter();
    t_bus_init();
    print_verdict();
  end
endmodule // mc_bank_logger_test
`default_nettype wire
